/* File: hdl/pctrh_consts.svh */
// timing counts, widths and reset values shared by both ends of the handshake
`ifndef PCTRH_CONSTS_SVH
`define PCTRH_CONSTS_SVH

`define PCTRH_LAT_MAX        6'h3f
`define PCTRH_LAT_BITS       6
`define PCTRH_TRK_BITS       4
`define PCTRH_MAX_SETS       4
`define PCTRH_RD_GAP         3
`define PCTRH_WR_GAP         4
`define PCTRH_CAL_CYCLES     16'h0040
`define PCTRH_TRK_CYCLES     8'h10
`define PCTRH_RESET_LAT      6'h00
`define PCTRH_RESET_RANK     4'h1

`endif

/* File: hdl/pctrh_pkg.sv */
// types shared by the sequencer end and the controller end
package pctrh_pkg;
	typedef enum logic [1:0] {
		PCTRH_SQ_IDLE = 2'h0,
		PCTRH_SQ_CAL  = 2'h1,
		PCTRH_SQ_DONE = 2'h3,
		PCTRH_SQ_TRK  = 2'h2
	} pctrh_seq_e;

	typedef enum logic [1:0] {
		PCTRH_CT_RUN  = 2'h0,
		PCTRH_CT_REQ  = 2'h1,
		PCTRH_CT_WAIT = 2'h3
	} pctrh_ctl_e;
endpackage

/* File: hdl/pctrh_if.sv */
// calibration, tracking and rank-select signals between controller and sequencer
`timescale 1ns/1ps
interface pctrh_if #(
	parameter int RATE  = 4,
	parameter int RANKS = 4,
	parameter int GROUPS = 1
);
	// calibration status
	logic                    cal_passed;
	logic                    cal_failed;
	logic                    cal_req;
	logic [6*GROUPS-1:0]     wr_lat;
	logic [5:0]              rd_lat;
	// tracking handshake
	logic [3:0]              trk_busy;
	logic [3:0]              refresh_done;
	logic [3:0]              long_idle;
	// rank selects, slot 0 in the low bits
	logic [RATE*RANKS-1:0]   wr_rank;
	logic [RATE*RANKS-1:0]   rd_rank;
	logic [RATE-1:0]         rd_en;
	logic [RATE-1:0]         dqs_burst;

	modport seq (
		output cal_passed, cal_failed, wr_lat, rd_lat, trk_busy,
		input  cal_req, refresh_done, long_idle, wr_rank, rd_rank, rd_en, dqs_burst
	);
	modport ctl (
		input  cal_passed, cal_failed, wr_lat, rd_lat, trk_busy,
		output cal_req, refresh_done, long_idle, wr_rank, rd_rank, rd_en, dqs_burst
	);
endinterface

/* File: hdl/pctrh_seq.sv */
// sequencer end: calibration status, tracking manager and shadow set select
`timescale 1ns/1ps
`include "pctrh_consts.svh"

// Contract
// - raise calibration passed after successful calibration
// - raise calibration failed when calibration fails
// - recalibration request resets sequencer, restarts calibration
// - report per-group write latency 0 to 63
// - equal latencies: controller uses low six bits
// - report read latency 0 to 63
// - phy-only: controller watches read valid instead
// - tracking periodically takes over controller interface
// - four-bit busy held while tracking runs
// - controller signals refresh done, awaits response
// - controller signals long idle, awaits response
// - write rank timed exactly like strobe burst
// - read rank with read enable, then held
// - ranks encoded one-hot per time slot
// - rank buses concatenated by slot, slot zero low
// - reads to different ranks spaced three cycles
// - writes to different ranks spaced four cycles
// - at most four shadow timing sets
// - per-rank settings stored and restored at switch
// - strobe burst precedes write valid, correct length
module pctrh_seq
	import pctrh_pkg::*;
#(
	parameter int RATE      = 4,
	parameter int RANKS     = 4,
	parameter int GROUPS    = 1,
	parameter int TRACKING  = 1,
	parameter logic [15:0] CAL_CYCLES = `PCTRH_CAL_CYCLES
) (
	// clock and reset
	input  wire logic              sys_clk_in,
	input  wire logic              reset_in,
	// link to controller
	pctrh_if.seq                   link,
	// calibration engine results, taken as the calibration ends
	input  wire logic              cal_ok_in,
	input  wire logic [6*GROUPS-1:0] meas_wr_lat_in,
	input  wire logic [5:0]        meas_rd_lat_in,
	input  wire logic [15:0]       meas_setting_in,
	// tracking request from interval timer
	input  wire logic              trk_due_in,
	// status toward user
	output logic [1:0]             active_set_out,
	output logic [15:0]            active_setting_out,
	output logic                   seq_owns_bus_out
);
	localparam int SETS = (RANKS < `PCTRH_MAX_SETS) ? RANKS : `PCTRH_MAX_SETS;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		pctrh_seq_e            st;
		logic [15:0]           cnt;
		logic [1:0]            cal_set;
		logic                  passed;
		logic                  failed;
		logic [6*GROUPS-1:0]   wlat;
		logic [5:0]            rlat;
		logic [3:0]            busy;
		logic [1:0]            act_set;
		logic [15:0]           act_val;
		logic [SETS*16-1:0]    shadow;
	} pctrh_seq_s;

	pctrh_seq_s cur_ff;
	pctrh_seq_s nxt_ff;

	// one-hot slot word to set index, lowest set bit wins
	function automatic logic [1:0] pctrh_onehot_idx(input logic [RANKS-1:0] w);
		logic [1:0] idx;
		idx = 2'h0;
		for (int i = RANKS - 1; i >= 0; i--) begin
			if (w[i]) begin
				idx = 2'(i % SETS); // extra physical ranks fold onto logical sets
			end
		end
		return idx;
	endfunction

	// newest non-empty slot of a rank bus, highest slot is latest in time
	function automatic logic [RANKS:0] pctrh_last_slot(input logic [RATE*RANKS-1:0] bus);
		logic [RANKS:0] r;
		r = '0;
		for (int s = 0; s < RATE; s++) begin
			if (|bus[s*RANKS +: RANKS]) begin
				r = {1'b1, bus[s*RANKS +: RANKS]}; // slot zero sits in low bits
			end
		end
		return r;
	endfunction

	logic [RANKS:0] wr_pick;
	logic [RANKS:0] rd_pick;
	assign wr_pick = pctrh_last_slot(link.wr_rank);
	assign rd_pick = pctrh_last_slot(link.rd_rank);

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	// request is a sync reset, so it sits above every state branch; the shadow set select below still runs
	always_comb begin
		nxt_ff = cur_ff;
		if (link.cal_req) begin
			nxt_ff.st     = PCTRH_SQ_IDLE;
			nxt_ff.cnt    = 16'h0000;
			nxt_ff.passed = 1'b0;
			nxt_ff.failed = 1'b0;
			nxt_ff.busy   = 4'h0;
		end else begin
			unique case (cur_ff.st)
				PCTRH_SQ_IDLE: begin
					nxt_ff.st      = PCTRH_SQ_CAL;
					nxt_ff.cnt     = 16'h0000;
					nxt_ff.cal_set = 2'h0;
					nxt_ff.passed  = 1'b0;
					nxt_ff.failed  = 1'b0;
				end
				PCTRH_SQ_CAL: begin
					nxt_ff.cnt = cur_ff.cnt + 16'h0001;
					if (cur_ff.cnt == CAL_CYCLES - 16'h0001) begin
						// each rank calibrated alone, result kept in its own set
						nxt_ff.shadow[cur_ff.cal_set*16 +: 16] = meas_setting_in;
						nxt_ff.cnt = 16'h0000;
						if (!cal_ok_in) begin
							nxt_ff.failed = 1'b1;
							nxt_ff.st     = PCTRH_SQ_DONE;
						end else if (32'(cur_ff.cal_set) == SETS - 1) begin
							nxt_ff.passed = 1'b1;
							nxt_ff.wlat   = meas_wr_lat_in;
							nxt_ff.rlat   = meas_rd_lat_in;
							nxt_ff.st     = PCTRH_SQ_DONE;
						end else begin
							nxt_ff.cal_set = cur_ff.cal_set + 2'h1;
						end
					end
				end
				PCTRH_SQ_DONE: begin
					// tracking only after a pass; a failed part waits for a request
					if (cur_ff.passed && TRACKING != 0 && trk_due_in &&
					    ((|link.refresh_done) || (|link.long_idle))) begin
						nxt_ff.st   = PCTRH_SQ_TRK;
						nxt_ff.busy = 4'hf;
						nxt_ff.cnt  = 16'h0000;
					end
				end
				PCTRH_SQ_TRK: begin
					nxt_ff.cnt = cur_ff.cnt + 16'h0001;
					if (cur_ff.cnt[7:0] == `PCTRH_TRK_CYCLES - 8'h01) begin
						nxt_ff.st   = PCTRH_SQ_DONE;
						nxt_ff.busy = 4'h0;
					end
				end
			endcase
		end
		// shadow set follows the rank selects; writes take precedence
		if (wr_pick[RANKS]) begin
			nxt_ff.act_set = pctrh_onehot_idx(wr_pick[RANKS-1:0]);
		end else if (rd_pick[RANKS]) begin
			nxt_ff.act_set = pctrh_onehot_idx(rd_pick[RANKS-1:0]);
		end
		nxt_ff.act_val = cur_ff.shadow[nxt_ff.act_set*16 +: 16];
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			cur_ff         <= '0;
			cur_ff.st      <= PCTRH_SQ_IDLE;
			cur_ff.wlat    <= '0;
			cur_ff.rlat    <= `PCTRH_RESET_LAT;
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	// outputs straight from flops
	assign link.cal_passed  = cur_ff.passed;
	assign link.cal_failed  = cur_ff.failed;
	assign link.wr_lat      = cur_ff.wlat;
	assign link.rd_lat      = cur_ff.rlat;
	assign link.trk_busy    = cur_ff.busy;
	assign active_set_out     = cur_ff.act_set;
	assign active_setting_out = cur_ff.act_val;
	assign seq_owns_bus_out   = cur_ff.busy[0]; // busy flop is set exactly while tracking
endmodule

/* File: hdl/pctrh_ctl.sv */
// controller end: recalibration, tracking handshake, rank selects with spacing
`timescale 1ns/1ps
`include "pctrh_consts.svh"

module pctrh_ctl
	import pctrh_pkg::*;
#(
	parameter int RATE   = 4,
	parameter int RANKS  = 4,
	parameter int GROUPS = 1
) (
	// clock and reset
	input  wire logic              sys_clk_in,
	input  wire logic              reset_in,
	// link to sequencer
	pctrh_if.ctl                   link,
	// user requests
	input  wire logic              recal_in,
	input  wire logic              refresh_in,
	input  wire logic              idle_exit_in,
	input  wire logic              rd_in,
	input  wire logic              wr_in,
	input  wire logic [1:0]        rank_in,
	// user status
	output logic                   ready_out,
	output logic                   accept_out,
	output logic [5:0]             wr_lat_out
);
	typedef struct packed {
		pctrh_ctl_e            st;
		logic                  req;
		logic [3:0]            rfd;
		logic [3:0]            lid;
		logic [RANKS-1:0]      rrank;
		logic [RANKS-1:0]      lwr;
		logic [3:0]            gap;
		logic                  wr_on;
		logic                  acc;
	} pctrh_ctl_s;

	pctrh_ctl_s cur_ff;
	pctrh_ctl_s nxt_ff;
	logic [RANKS-1:0] sel;
	logic             ok;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	// gap counts full-rate cycles: RATE per interface clock
	always_comb begin
		nxt_ff = cur_ff;
		sel = RANKS'(1) << rank_in;
		ok  = link.cal_passed && (link.trk_busy == 4'h0) && !cur_ff.req;
		nxt_ff.req   = recal_in;
		nxt_ff.wr_on = 1'b0;
		nxt_ff.acc   = 1'b0;
		nxt_ff.gap   = (cur_ff.gap > 4'(RATE)) ? cur_ff.gap - 4'(RATE) : 4'h0;
		unique case (cur_ff.st)
			PCTRH_CT_RUN: begin
				if (refresh_in) begin
					nxt_ff.rfd = 4'hf;
					nxt_ff.st  = PCTRH_CT_REQ;
				end else if (idle_exit_in) begin
					nxt_ff.lid = 4'hf;
					nxt_ff.st  = PCTRH_CT_REQ;
				end else if (ok && rd_in &&
				             (sel == cur_ff.rrank || cur_ff.gap == 4'h0)) begin
					nxt_ff.rrank = sel;
					nxt_ff.acc   = 1'b1;
					nxt_ff.gap   = 4'(`PCTRH_RD_GAP) + 4'(RATE);
				end else if (ok && wr_in &&
				             (sel == cur_ff.lwr || cur_ff.gap == 4'h0)) begin
					nxt_ff.lwr   = sel;
					nxt_ff.wr_on = 1'b1;
					nxt_ff.acc   = 1'b1;
					nxt_ff.gap   = 4'(`PCTRH_WR_GAP) + 4'(RATE);
				end
			end
			PCTRH_CT_REQ: begin
				// hold the request until the tracking manager answers busy, or drop it while calibration has not passed
				if (link.trk_busy != 4'h0 || !link.cal_passed) begin
					nxt_ff.rfd = 4'h0;
					nxt_ff.lid = 4'h0;
					nxt_ff.st  = PCTRH_CT_WAIT;
				end
			end
			PCTRH_CT_WAIT: begin
				if (link.trk_busy == 4'h0) begin
					nxt_ff.st = PCTRH_CT_RUN;
				end
			end
			default: begin
				nxt_ff.st = PCTRH_CT_RUN;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			cur_ff       <= '0;
			cur_ff.st    <= PCTRH_CT_RUN;
			cur_ff.req   <= 1'b1;
			cur_ff.rrank <= RANKS'(`PCTRH_RESET_RANK);
			cur_ff.lwr   <= RANKS'(`PCTRH_RESET_RANK);
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	// rank word replicated in every slot; write select shares strobe timing
	generate
		for (genvar s = 0; s < RATE; s++) begin : g_slot
			assign link.rd_rank[s*RANKS +: RANKS] = cur_ff.rrank;
			assign link.wr_rank[s*RANKS +: RANKS] = cur_ff.wr_on ? cur_ff.lwr : '0;
			assign link.dqs_burst[s] = cur_ff.wr_on;
			assign link.rd_en[s]     = cur_ff.acc && !cur_ff.wr_on;
		end
	endgenerate

	assign link.cal_req      = cur_ff.req;
	assign link.refresh_done = cur_ff.rfd;
	assign link.long_idle    = cur_ff.lid;
	assign ready_out         = link.cal_passed;
	assign accept_out        = cur_ff.acc;
	assign wr_lat_out        = link.wr_lat[5:0];
endmodule

/* File: sim/pctrh_link_asserts.sv */
// concurrent checks on the controller to sequencer link
`timescale 1ns/1ps
module pctrh_link_asserts (
	// clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        reset_in,
	// link signals
	input  wire logic        cal_passed,
	input  wire logic        cal_failed,
	input  wire logic        cal_req,
	input  wire logic [3:0]  trk_busy,
	input  wire logic [3:0]  refresh_done,
	input  wire logic [3:0]  long_idle,
	input  wire logic [15:0] wr_rank,
	input  wire logic [15:0] rd_rank,
	input  wire logic [3:0]  rd_en,
	input  wire logic [3:0]  dqs_burst
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);

	// --------------------------------
	// busy span counter
	// --------------------------------
	// a 16-cycle span is too long for a repetition, so count it
	logic [7:0] busy_len_ff;
	logic [7:0] nxt_busy_len;
	always_comb nxt_busy_len = (trk_busy != 4'h0) ? busy_len_ff + 8'h01 : 8'h00;
	always_ff @(posedge sys_clk_in) busy_len_ff <= reset_in ? 8'h00 : nxt_busy_len;

	// --------------------------------
	// properties
	// --------------------------------
	chk_status_excl: assert property (!(cal_passed && cal_failed))
		else $error("passed and failed high together");
	chk_req_clears: assert property (cal_req |=> !cal_passed && !cal_failed)
		else $error("status high after recalibration request");
	chk_busy_ones: assert property (trk_busy == 4'h0 || trk_busy == 4'hf)
		else $error("busy bits disagree");
	chk_busy_len: assert property ($fell(trk_busy[0]) |-> busy_len_ff == 8'h10)
		else $error("tracking span not 16 cycles");
	chk_busy_cause: assert property ($rose(trk_busy[0]) |-> $past(cal_passed)
		&& $past(refresh_done | long_idle) != 4'h0)
		else $error("tracking without passed calibration or handshake");
	chk_hs_held: assert property ((refresh_done | long_idle) != 4'h0 && trk_busy == 4'h0
		|=> (refresh_done | long_idle) != 4'h0)
		else $error("handshake dropped before busy");
	chk_wrank_burst: assert property ((dqs_burst != 4'h0) == (wr_rank != 16'h0))
		else $error("write rank not aligned to strobe burst");
	chk_rrank_hot: assert property ($onehot(rd_rank[3:0])
		&& rd_rank == {4{rd_rank[3:0]}})
		else $error("read rank not one-hot in every slot");
	chk_rrank_held: assert property (!$stable(rd_rank) |-> rd_en != 4'h0)
		else $error("read rank changed without a read");
	chk_rd_gap: assert property (rd_en != 4'h0 |=> rd_en == 4'h0 || $stable(rd_rank))
		else $error("rank switch between reads too close");
	chk_wr_gap: assert property (dqs_burst != 4'h0
		|=> dqs_burst == 4'h0 || wr_rank == $past(wr_rank))
		else $error("rank switch between writes too close");
endmodule

/* File: sim/tb_phy_calib_tracking_rank_handshake.sv */
// self-checking bench joining the sequencer end and the controller end
`timescale 1ns/1ps
module tb_phy_calib_tracking_rank_handshake;
	logic        sys_clk_in = 1'b0;
	logic        reset_in = 1'b1;
	logic        cal_ok = 1'b0, trk_due = 1'b0, recal = 1'b0, refresh = 1'b0;
	logic        idle_exit = 1'b0, rd = 1'b0, wr = 1'b0, ready, accept, prev_pass, owns;
	logic [1:0]  rank = 2'h0, aset;
	logic [5:0]  m_wr = 6'h00, m_rd = 6'h00, wr_lat_o;
	logic [15:0] m_set = 16'h0000, e, aval;
	logic [207:0] m_hist = '0;
	logic [63:0] e_set = '0;
	logic [15:0] q_rd[$], q_wr[$], q_cal[$];
	int          mismatches = 0, n_compared = 0, seed = 50960;

	pctrh_if #(.RATE(4), .RANKS(4), .GROUPS(1)) u_pctrh_if ();
	pctrh_seq #(.CAL_CYCLES(16'h0004)) u_pctrh_seq (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
		.link(u_pctrh_if.seq), .cal_ok_in(cal_ok), .meas_wr_lat_in(m_wr), .meas_rd_lat_in(m_rd),
		.meas_setting_in(m_set), .trk_due_in(trk_due), .active_set_out(aset),
		.active_setting_out(aval), .seq_owns_bus_out(owns));
	pctrh_ctl u_pctrh_ctl (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .link(u_pctrh_if.ctl),
		.recal_in(recal), .refresh_in(refresh), .idle_exit_in(idle_exit), .rd_in(rd), .wr_in(wr),
		.rank_in(rank), .ready_out(ready), .accept_out(accept), .wr_lat_out(wr_lat_o));
	pctrh_link_asserts u_pctrh_link_asserts (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
		.cal_passed(u_pctrh_if.cal_passed), .cal_failed(u_pctrh_if.cal_failed),
		.cal_req(u_pctrh_if.cal_req), .trk_busy(u_pctrh_if.trk_busy),
		.refresh_done(u_pctrh_if.refresh_done), .long_idle(u_pctrh_if.long_idle),
		.wr_rank(u_pctrh_if.wr_rank), .rd_rank(u_pctrh_if.rd_rank), .rd_en(u_pctrh_if.rd_en),
		.dqs_burst(u_pctrh_if.dqs_burst));

	// --------------------------------
	// clock, helpers
	// --------------------------------
	always #50 sys_clk_in = ~sys_clk_in;
	// settings change every cycle so a stale capture would show
	// history keeps what the sequencer saw on the last 13 edges, newest word low
	always @(posedge sys_clk_in) begin
		m_set <= 16'($random(seed));
		m_hist <= {m_hist[191:0], m_set};
	end

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s exp %h seen %h", name, exp, seen);
		end
	endtask

	task print_verdict;
		if (mismatches == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task cyc(input int n);
		repeat (n) @(posedge sys_clk_in);
	endtask

	// recalibrate with the given engine outcome and latencies
	task calib(input logic ok, input logic [5:0] wl, input logic [5:0] rl);
		@(posedge sys_clk_in);
		cal_ok <= ok;
		m_wr <= wl;
		m_rd <= rl;
		recal <= 1'b1;
		if (ok) q_cal.push_back({4'h0, wl, rl});
		@(posedge sys_clk_in);
		recal <= 1'b0;
		cyc(2);
		check("passed_low", {15'h0, u_pctrh_if.cal_passed}, 16'h0);
		for (int i = 0; i < 200 && u_pctrh_if.cal_passed !== 1'b1 && u_pctrh_if.cal_failed !== 1'b1; i++)
			@(posedge sys_clk_in);
		e = {14'h0, u_pctrh_if.cal_passed, u_pctrh_if.cal_failed};
		check("cal_result", e, ok ? 16'h2 : 16'h1);
		check("ready", {15'h0, ready}, {15'h0, ok});
	endtask

	// one-cycle request; spacing afterwards keeps rank gaps clear
	task access(input logic is_wr, input logic [1:0] r);
		@(posedge sys_clk_in);
		rd <= !is_wr;
		wr <= is_wr;
		rank <= r;
		if (is_wr) q_wr.push_back({4{4'h1 << r}});
		else q_rd.push_back({4{4'h1 << r}});
		@(posedge sys_clk_in);
		rd <= 1'b0;
		wr <= 1'b0;
		for (int i = 0; i < 4 && accept !== 1'b1; i++)
			@(posedge sys_clk_in);
		check("accept", {15'h0, accept}, 16'h1);
		cyc(3);
		if (!is_wr) check("active_set", {14'h0, aset}, {14'h0, r});
		if (!is_wr) check("active_setting", aval, e_set[r*16 +: 16]);
	endtask

	// handshake plus a read in the same cycle, which must be dropped
	task track(input logic use_idle);
		@(posedge sys_clk_in);
		trk_due <= 1'b1;
		refresh <= !use_idle;
		idle_exit <= use_idle;
		rd <= 1'b1;
		@(posedge sys_clk_in);
		refresh <= 1'b0;
		idle_exit <= 1'b0;
		rd <= 1'b0;
		for (int i = 0; i < 20 && u_pctrh_if.trk_busy !== 4'hf; i++)
			@(posedge sys_clk_in);
		check("busy", {12'h0, u_pctrh_if.trk_busy}, 16'hf);
		check("owns_bus", {15'h0, owns}, 16'h1);
		for (int i = 0; i < 40 && u_pctrh_if.trk_busy !== 4'h0; i++)
			@(posedge sys_clk_in);
		trk_due <= 1'b0;
		check("busy_end", {12'h0, u_pctrh_if.trk_busy}, 16'h0);
		check("owns_free", {15'h0, owns}, 16'h0);
	endtask

	// --------------------------------
	// result watcher
	// --------------------------------
	always @(posedge sys_clk_in) begin
		prev_pass <= u_pctrh_if.cal_passed;
		if (!reset_in && u_pctrh_if.cal_passed === 1'b1 && prev_pass !== 1'b1) begin
			e = q_cal.size() ? q_cal.pop_front() : 16'hxxxx;
			// sets are captured four cycles apart here, the last on the edge before pass
			e_set = {m_hist[15:0], m_hist[79:64], m_hist[143:128], m_hist[207:192]};
			check("latencies", {4'h0, u_pctrh_if.wr_lat, u_pctrh_if.rd_lat}, e);
			check("wr_lat_out", {10'h0, wr_lat_o}, {10'h0, e[11:6]});
		end
		if (!reset_in && u_pctrh_if.rd_en != 4'h0)
			check("rd_rank", u_pctrh_if.rd_rank, q_rd.size() ? q_rd.pop_front() : 16'hxxxx);
		if (!reset_in && u_pctrh_if.dqs_burst != 4'h0)
			check("wr_rank", u_pctrh_if.wr_rank, q_wr.size() ? q_wr.pop_front() : 16'hxxxx);
	end

	// --------------------------------
	// main sequence and watchdog
	// --------------------------------
	initial begin
		cyc(2);
		reset_in <= 1'b0;
		calib(1'b0, 6'h15, 6'h2a);
		calib(1'b1, 6'($random(seed)), 6'h3f);
		for (int k = 0; k < 8; k++)
			access(k[2], 2'(k));
		for (int k = 0; k < 12; k++)
			access(1'($random(seed)), 2'($random(seed)));
		track(1'b0);
		track(1'b1);
		access(1'b0, 2'h3);
		calib(1'b1, 6'h00, 6'($random(seed)));
		cyc(5);
		print_verdict;
	end

	// about 220 cycles expected, so 5000 means a hang
	initial begin
		#500000;
		mismatches++;
		print_verdict;
	end
endmodule
